// ==== core/dcdc_fault_supervisor.v ====
// converter fault supervisor with persistence filters, off latch and apb status
`timescale 1ns/100ps
`include "fault_supervisor_defines.vh"
module dcdc_fault_supervisor #(
   parameter PERSIST_CNT = `PERSIST_CYCLES,
   parameter SS_TO_CNT   = `SS_TIMEOUT_CYCLES,
   parameter CW          = 22
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // analog comparator results
   input  wire        enable_input_voltage,
   input  wire        supply_ok,
   input  wire        soft_start_arm,
   input  wire        soft_start_done_threshold,
   input  wire        uv_cmp,
   input  wire        ov_cmp,
   input  wire        freq_resistor_open_short,
   input  wire        thermal_cutoff,
   input  wire        overcurrent,
   input  wire        cycle_start,
   // power stage and host
   output reg         stage_enable,
   output reg         high_side_on,
   output reg         output_pull_low,
   output reg         soft_start_run,
   output reg         standby,
   output reg         fault_latch_flag_n,
   output reg         fault_latch_flag_oe,
   output reg         irq
);

   // two-stage synchronisers on all comparator inputs
   localparam NI = 10;
   wire [NI-1:0] raw_in;
   reg  [NI-1:0] sync1_r;
   reg  [NI-1:0] sync2_r;
   assign raw_in = {cycle_start, overcurrent, thermal_cutoff, freq_resistor_open_short,
                    ov_cmp, uv_cmp, soft_start_done_threshold, soft_start_arm,
                    supply_ok, enable_input_voltage};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= {NI{1'b0}};
         sync2_r <= {NI{1'b0}};
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end
   wire en_s   = sync2_r[0];
   wire sup_s  = sync2_r[1];
   wire arm_s  = sync2_r[2];
   wire done_s = sync2_r[3];
   wire uv_s   = sync2_r[4];
   wire ov_s   = sync2_r[5];
   wire rt_s   = sync2_r[6];
   wire th_s   = sync2_r[7];
   wire oc_s   = sync2_r[8];
   wire cyc_s  = sync2_r[9];

   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg        lockout_r;
   reg        uv_latched_r;
   reg  [5:0] status_r;
   reg  [5:0] mask_r;
   reg        ctrl_irq_en_r;
   reg  [CW-1:0] ss_cnt_r;

   // hysteresis lives in the comparator; here lockout just follows the synced level
   wire up = sup_s;
   wire armed = en_s && arm_s && up;

   // persistence filters: uv, ov, rt, oc
   wire [3:0] cond = {oc_s && up,
                      rt_s && up,
                      ov_s && armed,
                      uv_s && armed};
   wire [3:0] expired;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : persist
         reg [CW-1:0] cnt_r;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               cnt_r <= {CW{1'b0}};
            else if (!cond[g] || state_r == `ST_LATCH)
               cnt_r <= {CW{1'b0}};
            else if (cnt_r != PERSIST_CNT[CW-1:0])
               cnt_r <= cnt_r + 1'b1;
         end
         assign expired[g] = (cnt_r == PERSIST_CNT[CW-1:0]) && cond[g];
      end
   endgenerate

   wire active  = (state_r == `ST_SOFT) || (state_r == `ST_RUN);
   wire persist_trip = |expired;
   wire ss_trip = (state_r == `ST_SOFT) && !done_s &&
                  (ss_cnt_r == SS_TO_CNT[CW-1:0]);

   always @* begin
      state_nxt = state_r;
      case (state_r)
         `ST_OFF:   if (en_s && up) state_nxt = `ST_SOFT;
         `ST_SOFT: begin
            if (!en_s || !up) state_nxt = `ST_OFF;
            else if (persist_trip || ss_trip) state_nxt = `ST_LATCH;
            else if (done_s) state_nxt = `ST_RUN;
         end
         `ST_RUN: begin
            if (!en_s || !up) state_nxt = `ST_OFF;
            else if (persist_trip) state_nxt = `ST_LATCH;
         end
         `ST_LATCH: if (!en_s) state_nxt = `ST_OFF;
         default:   state_nxt = `ST_OFF;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r      <= `ST_OFF;
         ss_cnt_r     <= {CW{1'b0}};
         uv_latched_r <= 1'b0;
         lockout_r    <= 1'b1;
      end else begin
         state_r   <= state_nxt;
         lockout_r <= !up;
         if (state_r != `ST_SOFT)
            ss_cnt_r <= {CW{1'b0}};
         else if (ss_cnt_r != SS_TO_CNT[CW-1:0])
            ss_cnt_r <= ss_cnt_r + 1'b1;
         if (state_nxt == `ST_OFF)
            uv_latched_r <= 1'b0;
         else if (state_r != `ST_LATCH && state_nxt == `ST_LATCH && expired[`EV_UV])
            uv_latched_r <= 1'b1;
      end
   end

   // power stage outputs, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_enable        <= 1'b0;
         high_side_on        <= 1'b0;
         output_pull_low     <= 1'b0;
         soft_start_run      <= 1'b0;
         standby             <= 1'b1;
         fault_latch_flag_n  <= 1'b1;
         fault_latch_flag_oe <= 1'b0;
      end else begin
         stage_enable    <= active && !th_s;
         output_pull_low <= (state_r == `ST_LATCH) || th_s;
         soft_start_run  <= (state_r == `ST_SOFT);
         standby         <= lockout_r;
         // on-phase starts each cycle, overcurrent ends it at once
         if (!active || th_s || oc_s)
            high_side_on <= 1'b0;
         else if (cyc_s)
            high_side_on <= 1'b1;
         // open drain: pulled low only while the uv latch holds
         fault_latch_flag_n  <= 1'b0;
         fault_latch_flag_oe <= uv_latched_r;
      end
   end

   // apb: zero wait states, errors on unmapped addresses
   wire acc   = psel && penable;
   wire wr    = acc && pwrite;
   wire rd    = acc && !pwrite;
   wire hit   = (paddr == `ADDR_STATUS) || (paddr == `ADDR_MASK) ||
                (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATE);
   assign pready  = 1'b1;
   assign pslverr = acc && !hit;

   wire [5:0] ev_now = {th_s && active,
                        ss_trip,
                        expired[3:0] & {4{active}}};
   wire status_rd = rd && (paddr == `ADDR_STATUS);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r      <= 6'h00;
         mask_r        <= `MASK_RESET;
         ctrl_irq_en_r <= `CTRL_RESET;
         prdata        <= 32'h00000000;
         irq           <= 1'b0;
      end else begin
         // read clears, but a new event in the same cycle survives
         status_r <= (status_rd ? 6'h00 : status_r) | ev_now;
         if (wr && paddr == `ADDR_MASK)
            mask_r <= pwdata[`EV_W-1:0];
         if (wr && paddr == `ADDR_CTRL)
            ctrl_irq_en_r <= pwdata[0];
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `ADDR_STATUS: prdata <= {26'h0000000, status_r | ev_now};
               `ADDR_MASK:   prdata <= {26'h0000000, mask_r};
               `ADDR_CTRL:   prdata <= {31'h00000000, ctrl_irq_en_r};
               `ADDR_STATE:  prdata <= {27'h0000000, lockout_r, uv_latched_r, th_s, state_r};
               default:      prdata <= 32'h00000000;
            endcase
         end
         irq <= ctrl_irq_en_r && |(status_r & mask_r);
      end
   end

endmodule // dcdc_fault_supervisor

// ==== core/fault_supervisor_defines.vh ====
// constants, register map and timing for the converter fault supervisor
// Functional notes
// - start only once enable comparator reads high
// - undervoltage persisting 500us latches output low
// - latched undervoltage drives fault flag low
// - undervoltage check armed only enable and soft-start
// - overvoltage persisting 500us latches output low
// - overvoltage check armed only enable and soft-start
// - supply lockout enters standby until supply recovers
// - resistor open/short persisting 500us latches off
// - resistor monitoring always active after supply up
// - soft start not done in 64ms latches
// - latch held until enable driven low once
// - overtemperature forces output low immediately
// - overcurrent ends each cycle's high-side on-phase
// - overcurrent persisting 500us latches output low
`ifndef FAULT_SUPERVISOR_DEFINES_VH
`define FAULT_SUPERVISOR_DEFINES_VH

`define CLK_FREQ_KHZ      50000
`define PERSIST_TIME_US   500
`define SS_TIMEOUT_MS     64
`define PERSIST_CYCLES    ((`PERSIST_TIME_US * `CLK_FREQ_KHZ) / 1000)
`define SS_TIMEOUT_CYCLES (`SS_TIMEOUT_MS * `CLK_FREQ_KHZ)

`define ADDR_STATUS       12'h000
`define ADDR_MASK         12'h004
`define ADDR_CTRL         12'h008
`define ADDR_STATE        12'h00C

`define MASK_RESET        6'h00
`define CTRL_RESET        1'h0

// event bit positions in status and mask
`define EV_UV             0
`define EV_OV             1
`define EV_RT             2
`define EV_OC             3
`define EV_SS             4
`define EV_TH             5
`define EV_W              6

`define ST_OFF            2'h0
`define ST_SOFT           2'h1
`define ST_RUN            2'h2
`define ST_LATCH          2'h3

`endif

// ==== testbench/fault_supervisor_chk.sv ====
// port checks for the converter fault supervisor
`timescale 1ns/100ps
module fault_supervisor_chk #(parameter int PERSIST_CNT = 20) (
   // clock and reset
   input wire logic        pclk, presetn,
   // apb
   input wire logic        psel, penable, pslverr,
   input wire logic [11:0] paddr,
   // comparators
   input wire logic        enable_input_voltage, supply_ok, soft_start_arm, uv_cmp,
   input wire logic        thermal_cutoff, overcurrent,
   // stage and host
   input wire logic        stage_enable, high_side_on, output_pull_low, standby,
   input wire logic        fault_latch_flag_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int uv_run;
   // armed run length, restarts whenever the condition breaks
   always @(posedge pclk or negedge presetn)
      if (!presetn) uv_run <= 0;
      else uv_run <= (uv_cmp && soft_start_arm && enable_input_voltage) ? uv_run + 1 : 0;
   sequence en_up;
      enable_input_voltage && supply_ok;
   endsequence
   chk_flag_uv: assert property (fault_latch_flag_oe |-> output_pull_low)
      else $error("flag pulled without output low");
   chk_uv_filter: assert property ($rose(fault_latch_flag_oe) |-> uv_run >= PERSIST_CNT)
      else $error("undervoltage latch too early");
   chk_thermal_low: assert property (thermal_cutoff [*5] |-> output_pull_low && !stage_enable)
      else $error("thermal did not stop stage");
   chk_en_off: assert property (!enable_input_voltage [*5] |-> !stage_enable)
      else $error("stage runs with enable low");
   chk_oc_cut: assert property (overcurrent [*5] |-> !high_side_on)
      else $error("high side on under overcurrent");
   chk_lock_enter: assert property (!supply_ok [*5] |-> standby && !stage_enable)
      else $error("no standby at lockout");
   chk_lock_exit: assert property (supply_ok [*6] |-> !standby)
      else $error("standby after supply ok");
   chk_latch_hold: assert property (en_up [*5] ##0 fault_latch_flag_oe |=> fault_latch_flag_oe)
      else $error("latch dropped with enable high");
   chk_bad_addr: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
      else $error("unmapped access not refused");
endmodule // fault_supervisor_chk
bind dcdc_fault_supervisor fault_supervisor_chk #(.PERSIST_CNT(PERSIST_CNT)) u_chk (
   .pclk, .presetn, .psel, .penable, .pslverr, .paddr, .enable_input_voltage, .supply_ok,
   .soft_start_arm, .uv_cmp, .thermal_cutoff, .overcurrent, .stage_enable, .high_side_on,
   .output_pull_low, .standby, .fault_latch_flag_oe);

// ==== testbench/host_model.sv ====
// host side: drives enable, pull-up on the fault flag pin
`timescale 1ns/100ps
module host_model (
   // clock and command
   input  wire logic pclk,
   input  wire logic off_req,
   // device side
   input  wire logic flag_n,
   input  wire logic flag_oe,
   output logic      en,
   output logic      flag_pin
);
   initial en = 1'b0;
   // released pin floats up to the pull-up level
   assign flag_pin = flag_oe ? flag_n : 1'b1;
   // only an enable low phase releases the latch
   always @(posedge pclk) en <= !off_req;
endmodule // host_model

// ==== testbench/tb.sv ====
// self-checking bench for the converter fault supervisor
`timescale 1ns/100ps
module tb;
   localparam int PC = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, m, seed = 32'hD5BDF85C;
   logic pready, pslverr, sup = 1, arm = 0, done = 0, th = 0, cyc = 0, off = 1;
   logic [3:0] flt = '0;
   logic en, pin, stg, hs, pl, ssr, stb, fn, foe, irq;
   int err_count = 0, check_count = 0, k, n;
   always #10 pclk = ~pclk;
   host_model u_host_model (.pclk, .off_req(off), .flag_n(fn), .flag_oe(foe), .en,
      .flag_pin(pin));
   dcdc_fault_supervisor #(.PERSIST_CNT(PC), .SS_TO_CNT(200)) u_dcdc_fault_supervisor (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .enable_input_voltage(en), .supply_ok(sup), .soft_start_arm(arm),
      .soft_start_done_threshold(done), .uv_cmp(flt[0]), .ov_cmp(flt[1]),
      .freq_resistor_open_short(flt[2]), .overcurrent(flt[3]), .thermal_cutoff(th),
      .cycle_start(cyc), .stage_enable(stg), .high_side_on(hs), .output_pull_low(pl),
      .soft_start_run(ssr), .standby(stb), .fault_latch_flag_n(fn),
      .fault_latch_flag_oe(foe), .irq);
   function logic [31:0] xs();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk); penable <= 1;
      // only the watchdog ends a wait that never sees pready
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; se = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task start();
      off <= 0; arm <= 1; done <= 1; cyc <= 1; repeat (10) @(posedge pclk);
      apb(0, 12'h00C, 0); chk(rd[1:0], 2, "run");
      chk(stg, 1, "stage on");
      chk(hs, 1, "high side on");
   endtask
   task restart();
      off <= 1; repeat (6) @(posedge pclk);
      apb(0, 12'h00C, 0); chk(rd[3:0], 0, "off");
      start();
   endtask
   task close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge pclk); presetn <= 1;
      repeat (4) @(posedge pclk); chk(stg, 0, "held off");
      apb(0, 12'h010, 0); chk(se, 1, "unmapped");
      m = xs(); apb(1, 12'h004, m); apb(0, 12'h004, 0); chk(rd, m & 32'h3F, "mask");
      apb(1, 12'h004, 32'h3F); apb(1, 12'h008, 1);
      start();
      for (k = 0; k < 4; k++) begin
         arm <= 0;
         // two glitches: uv and ov run past the filter with arm low; rt and oc each short of the filter, together past it
         repeat (2) begin
            n = k < 2 ? PC + 8 : PC / 2 + 1 + xs() % 6;
            flt[k] <= 1; repeat (n) @(posedge pclk);
            if (k == 3) chk(hs, 0, "oc cut");
            flt[k] <= 0; repeat (4) @(posedge pclk);
         end
         apb(0, 12'h00C, 0); chk(rd[1:0], 2, "filtered");
         arm <= k != 2; flt[k] <= 1; repeat (PC + 8) @(posedge pclk); flt[k] <= 0;
         chk(irq, 1, "irq");
         apb(0, 12'h000, 0); chk(rd, 1 << k, "status");
         apb(0, 12'h00C, 0); chk(rd[3:0], k == 0 ? 11 : 3, "latched");
         chk(pin, k != 0, "flag pin");
         chk(irq, 0, "irq cleared");
         restart();
         $display("fault %0d done", k);
      end
      sup <= 0; repeat (6) @(posedge pclk); chk(stb, 1, "standby");
      apb(0, 12'h00C, 0); chk(rd[4:0], 16, "lockout");
      sup <= 1; repeat (6) @(posedge pclk); chk(stb, 0, "resume");
      th <= 1; repeat (6) @(posedge pclk); chk(pl, 1, "thermal");
      th <= 0; done <= 0; off <= 1; repeat (6) @(posedge pclk);
      off <= 0; repeat (100) @(posedge pclk);
      chk(ssr, 1, "soft start running");
      repeat (115) @(posedge pclk);
      apb(0, 12'h00C, 0); chk(rd[1:0], 3, "ss timeout");
      apb(0, 12'h000, 0); chk(rd, 32'h30, "ss status");
      restart();
      $display("lockout thermal timeout done");
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      close_out();
   end
endmodule // tb
